// [rtl/hpc_consts.vh]
// Purpose: constants shared by the host/port status register block
// Assumes: 36-bit register, bit 0 is the least significant bit
// Notes:   definitions only
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH

// ==================================================================
// register width and field positions
`define HPC_REG_W          36
`define HPC_B_PRESENT      0
`define HPC_B_DIAG_REQ     1
`define HPC_B_DIAG_CHG     2
`define HPC_B_RSVD3        3
`define HPC_B_EXDEP_REQ    4
`define HPC_B_INTR_REQ     5
`define HPC_B_CS_PAR_ERR   6
`define HPC_B_CONTENTION   7
`define HPC_B_CLEAR_PORT   18
`define HPC_B_BUS_PAR_ERR  24
`define HPC_B_RUN          32
`define HPC_B_PI_LO        33
`define HPC_B_PI_HI        35

// ==================================================================
// levels and reset values
`define HPC_PI_W           3
`define HPC_EXDEP_LEVEL    3'h0
`define HPC_PI_RESET       3'h1
`define HPC_FLAGS_RESET    1'b0
// nonvectored trap base, octal 40
`define HPC_NONVEC_BASE    8'h20
`define HPC_NONVEC_W       8

`endif

// [rtl/hpc_cs_parity.v]
// Purpose: parity check on words read from the control store
// Assumes: odd parity over word plus parity bit; inputs synchronous
// Notes:   force input makes a deliberate error for breakpoints
`timescale 1ns/1ps
`include "hpc_consts.vh"

module hpc_cs_parity #(
   parameter WORD_W = 48
) (
   input  wire              clk_in,
   input  wire              rst_b_in,
   input  wire              word_valid_in,
   input  wire [WORD_W-1:0] word_in,
   input  wire              parity_in,
   input  wire              force_err_in,
   output reg               err_pulse_out
);

   // ===============================================================
   // parity reduction
   wire odd_ok;

   assign odd_ok = ^{word_in, parity_in};

   // ===============================================================
   // error pulse, one cycle per bad word
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         err_pulse_out <= 1'b0;
      end else begin
         // forcing only acts on a real fetch so the halt lands on that word
         err_pulse_out <= word_valid_in & (~odd_ok | force_err_in);
      end
   end

endmodule // hpc_cs_parity

// [rtl/hpc_csr_status.v]
// Purpose: bits 0-7, 18, 24 and 32-35 of the shared host/port control and status register
// Assumes: all strobes synchronous to clk_in and one cycle wide
// Notes:   host writes arrive as the output-control instruction strobe
`timescale 1ns/1ps
`include "hpc_consts.vh"

// How it works
// - presence reads 1 to host, 0 to port
// - access request strobe sets diag request
// - port read or load clears diag request
// - clear-port or bus reset clears request bits
// - host write sets changed; port read clears
// - bus parity error also sets changed
// - bit three has no function
// - examine/deposit request raises level zero interrupt
// - examine/deposit strobe sets its request
// - examine/deposit request clears on sequence completion
// - strobe, parity or contention sets interrupt request
// - interrupt request clears on sequence completion
// - parity error halts, interrupts, forces trap
// - run bit ignored while parity error set
// - control store parity error sets flag
// - forced parity error acts as breakpoint
// - parity flag cleared by write, clear, reset
module hpc_csr_status #(
   parameter CS_WORD_W = 48
) (
   input  wire                   clk_in,
   input  wire                   rst_b_in,
   // host side
   input  wire                   host_output_control_instruction_in,
   input  wire [`HPC_REG_W-1:0]  host_wdata_in,
   input  wire                   bus_reset_in,
   input  wire                   bus_parity_detect_in,
   input  wire                   exdep_seq_done_in,
   input  wire                   intr_seq_done_in,
   output reg  [`HPC_REG_W-1:0]  host_rdata_out,
   output wire                   exdep_intr_out,
   output wire [`HPC_PI_W-1:0]   exdep_intr_level_out,
   output wire                   intr_out,
   output wire [`HPC_PI_W-1:0]   intr_level_out,
   // port microprocessor side
   input  wire                   port_access_request_strobe_in,
   input  wire                   port_register_read_strobe_in,
   input  wire                   port_register_load_strobe_in,
   input  wire                   port_examine_deposit_strobe_in,
   input  wire                   port_interrupt_request_strobe_in,
   input  wire                   internal_bus_contention_error_in,
   input  wire                   cs_word_valid_in,
   input  wire [CS_WORD_W-1:0]   cs_word_in,
   input  wire                   cs_parity_in,
   input  wire                   cs_force_err_in,
   output reg  [`HPC_REG_W-1:0]  port_rdata_out,
   output wire                   microprocessor_run_bit_out,
   output reg                    nonvec_trap_out,
   output reg  [`HPC_NONVEC_W-1:0] nonvec_addr_out
);

   // ===============================================================
   // state
   reg                    diag_access_request_flag_ff;
   reg                    diag_register_changed_flag_ff;
   reg                    examine_deposit_request_ff;
   reg                    interrupt_request_ff;
   reg                    control_store_parity_error_ff;
   reg                    contention_error_ff;
   reg                    bus_parity_error_flag_ff;
   reg                    microprocessor_run_bit_ff;
   reg [`HPC_PI_W-1:0]    pi_level_ff;

   reg                    nxt_diag_req;
   reg                    nxt_diag_chg;
   reg                    nxt_exdep;
   reg                    nxt_intr;
   reg                    nxt_cs_par;
   reg                    nxt_contention;
   reg                    nxt_bus_par;
   reg                    nxt_run;
   reg [`HPC_PI_W-1:0]    nxt_pi;

   wire                   cs_par_pulse;
   wire                   host_wr;
   wire                   clear_all;
   wire                   halt_event;

   // ===============================================================
   // control store parity checker
   // checker is registered, so a parity halt lands two edges after the fetch
   hpc_cs_parity #(
      .WORD_W        (CS_WORD_W)
   ) u_cs_parity (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .word_valid_in (cs_word_valid_in),
      .word_in       (cs_word_in),
      .parity_in     (cs_parity_in),
      .force_err_in  (cs_force_err_in),
      .err_pulse_out (cs_par_pulse)
   );

   // ===============================================================
   // common terms
   assign host_wr    = host_output_control_instruction_in;
   // clear-port is a strobe only, never stored as a bit
   // clear-port write or bus reset
   assign clear_all  = bus_reset_in | (host_wr & host_wdata_in[`HPC_B_CLEAR_PORT]);
   // contention halts too: a bus driven twice leaves data unusable
   // halting events
   assign halt_event = cs_par_pulse | internal_bus_contention_error_in;

   // ===============================================================
   // next state; hardware sets beat strobe clears, clear_all beats all
   // later assignments below win, so their order sets the priority
   always @* begin
      nxt_diag_req   = diag_access_request_flag_ff;
      nxt_diag_chg   = diag_register_changed_flag_ff;
      nxt_exdep      = examine_deposit_request_ff;
      nxt_intr       = interrupt_request_ff;
      nxt_cs_par     = control_store_parity_error_ff;
      nxt_contention = contention_error_ff;
      nxt_bus_par    = bus_parity_error_flag_ff;
      nxt_run        = microprocessor_run_bit_ff;
      nxt_pi         = pi_level_ff;

      if (port_register_read_strobe_in | port_register_load_strobe_in) begin
         nxt_diag_req = 1'b0;
      end
      if (port_access_request_strobe_in) begin
         nxt_diag_req = 1'b1;
      end

      if (port_register_read_strobe_in) begin
         nxt_diag_chg = 1'b0;
      end
      if (host_wr | bus_parity_detect_in) begin
         nxt_diag_chg = 1'b1;
      end

      if (exdep_seq_done_in) begin
         nxt_exdep = 1'b0;
      end
      if (port_examine_deposit_strobe_in) begin
         nxt_exdep = 1'b1;
      end

      if (intr_seq_done_in) begin
         nxt_intr = 1'b0;
      end
      if (port_interrupt_request_strobe_in | halt_event) begin
         nxt_intr = 1'b1;
      end

      // host register fields: run, level, write-one-to-clear parity
      if (host_wr) begin
         nxt_pi = host_wdata_in[`HPC_B_PI_HI:`HPC_B_PI_LO];
         // no restart while parity error stands
         if (!control_store_parity_error_ff && !contention_error_ff) begin
            nxt_run = host_wdata_in[`HPC_B_RUN];
         end else begin
            nxt_run = 1'b0;
         end
         // write one clears both parity flags
         if (host_wdata_in[`HPC_B_BUS_PAR_ERR]) begin
            nxt_bus_par = 1'b0;
            nxt_cs_par  = 1'b0;
         end
      end
      if (bus_parity_detect_in) begin
         nxt_bus_par = 1'b1;
      end

      // detected or forced parity error sets
      if (cs_par_pulse) begin
         nxt_cs_par = 1'b1;
      end
      if (internal_bus_contention_error_in) begin
         nxt_contention = 1'b1;
      end
      if (halt_event) begin
         nxt_run = 1'b0;
      end

      if (clear_all) begin
         nxt_diag_req   = 1'b0;
         nxt_diag_chg   = 1'b0;
         nxt_exdep      = 1'b0;
         nxt_intr       = 1'b0;
         nxt_cs_par     = 1'b0;
         nxt_contention = 1'b0;
         nxt_bus_par    = 1'b0;
         nxt_run        = 1'b0;
      end
   end

   // ===============================================================
   // state registers
   // flags and run share one reset value; the level starts at one
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         diag_access_request_flag_ff   <= `HPC_FLAGS_RESET;
         diag_register_changed_flag_ff <= `HPC_FLAGS_RESET;
         examine_deposit_request_ff    <= `HPC_FLAGS_RESET;
         interrupt_request_ff          <= `HPC_FLAGS_RESET;
         control_store_parity_error_ff <= `HPC_FLAGS_RESET;
         contention_error_ff           <= `HPC_FLAGS_RESET;
         bus_parity_error_flag_ff      <= `HPC_FLAGS_RESET;
         microprocessor_run_bit_ff     <= `HPC_FLAGS_RESET;
         pi_level_ff                   <= `HPC_PI_RESET;
      end else begin
         diag_access_request_flag_ff   <= nxt_diag_req;
         diag_register_changed_flag_ff <= nxt_diag_chg;
         examine_deposit_request_ff    <= nxt_exdep;
         interrupt_request_ff          <= nxt_intr;
         control_store_parity_error_ff <= nxt_cs_par;
         contention_error_ff           <= nxt_contention;
         bus_parity_error_flag_ff      <= nxt_bus_par;
         microprocessor_run_bit_ff     <= nxt_run;
         pi_level_ff                   <= nxt_pi;
      end
   end

   // ===============================================================
   // interrupt requests follow the flags with no extra delay
   // level zero for examine/deposit
   assign exdep_intr_out       = examine_deposit_request_ff;
   assign exdep_intr_level_out = `HPC_EXDEP_LEVEL;
   // zero is kept for examine/deposit, so a general request never uses it
   // host-chosen level; zero maps to one so it stays in range
   assign intr_out             = interrupt_request_ff;
   assign intr_level_out       = (pi_level_ff == 3'h0) ? 3'h1 : pi_level_ff;
   assign microprocessor_run_bit_out        = microprocessor_run_bit_ff;

   // ===============================================================
   // forced nonvectored trap, address base plus twice the level
   // level captured with the event; a later level write cannot move it
   // trap one cycle after the halt event
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nonvec_trap_out <= 1'b0;
         nonvec_addr_out <= `HPC_NONVEC_BASE;
      end else begin
         nonvec_trap_out <= halt_event;
         if (halt_event) begin
            nonvec_addr_out <= `HPC_NONVEC_BASE + {4'h0, intr_level_out, 1'b0};
         end
      end
   end

   // ===============================================================
   // read views, registered; other bits read zero
   // registered for clean timing; costs one cycle behind the flags
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         host_rdata_out <= {`HPC_REG_W{1'b0}};
         port_rdata_out <= {`HPC_REG_W{1'b0}};
      end else begin
         host_rdata_out <= {`HPC_REG_W{1'b0}};
         port_rdata_out <= {`HPC_REG_W{1'b0}};
         host_rdata_out[`HPC_B_PRESENT]     <= 1'b1;
         port_rdata_out[`HPC_B_PRESENT]     <= 1'b0;
         host_rdata_out[`HPC_B_RSVD3]       <= 1'b0;
         port_rdata_out[`HPC_B_RSVD3]       <= 1'b0;
         host_rdata_out[`HPC_B_DIAG_REQ]    <= diag_access_request_flag_ff;
         port_rdata_out[`HPC_B_DIAG_REQ]    <= diag_access_request_flag_ff;
         host_rdata_out[`HPC_B_DIAG_CHG]    <= diag_register_changed_flag_ff;
         port_rdata_out[`HPC_B_DIAG_CHG]    <= diag_register_changed_flag_ff;
         host_rdata_out[`HPC_B_EXDEP_REQ]   <= examine_deposit_request_ff;
         port_rdata_out[`HPC_B_EXDEP_REQ]   <= examine_deposit_request_ff;
         host_rdata_out[`HPC_B_INTR_REQ]    <= interrupt_request_ff;
         port_rdata_out[`HPC_B_INTR_REQ]    <= interrupt_request_ff;
         host_rdata_out[`HPC_B_CS_PAR_ERR]  <= control_store_parity_error_ff;
         port_rdata_out[`HPC_B_CS_PAR_ERR]  <= control_store_parity_error_ff;
         host_rdata_out[`HPC_B_CONTENTION]  <= contention_error_ff;
         port_rdata_out[`HPC_B_CONTENTION]  <= contention_error_ff;
         host_rdata_out[`HPC_B_BUS_PAR_ERR] <= bus_parity_error_flag_ff;
         port_rdata_out[`HPC_B_BUS_PAR_ERR] <= bus_parity_error_flag_ff;
         host_rdata_out[`HPC_B_RUN]         <= microprocessor_run_bit_ff;
         port_rdata_out[`HPC_B_RUN]         <= microprocessor_run_bit_ff;
         host_rdata_out[`HPC_B_PI_HI:`HPC_B_PI_LO] <= pi_level_ff;
         port_rdata_out[`HPC_B_PI_HI:`HPC_B_PI_LO] <= pi_level_ff;
      end
   end

endmodule // hpc_csr_status

// [testbench/hpc_csr_monitor.sv]
// Purpose: port-level checks on the status register block
// Assumes: one clock domain, strobes one cycle wide
// Notes:   bound to every hpc_csr_status instance
`timescale 1ns/1ps
`include "hpc_consts.vh"

module hpc_csr_monitor (
   input wire logic                  clk_in,
   input wire logic                  rst_b_in,
   input wire logic                  host_output_control_instruction_in,
   input wire logic [`HPC_REG_W-1:0] host_wdata_in,
   input wire logic                  bus_reset_in,
   input wire logic                  exdep_seq_done_in,
   input wire logic                  intr_seq_done_in,
   input wire logic                  port_examine_deposit_strobe_in,
   input wire logic                  port_interrupt_request_strobe_in,
   input wire logic                  internal_bus_contention_error_in,
   input wire logic [`HPC_REG_W-1:0] host_rdata_out,
   input wire logic [`HPC_REG_W-1:0] port_rdata_out,
   input wire logic                  exdep_intr_out,
   input wire logic [`HPC_PI_W-1:0]  exdep_intr_level_out,
   input wire logic                  intr_out,
   input wire logic [`HPC_PI_W-1:0]  intr_level_out,
   input wire logic                  microprocessor_run_bit_out,
   input wire logic                  nonvec_trap_out,
   input wire logic [7:0]            nonvec_addr_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========================================
   // clear-port or bus reset, beats every set
   wire clr = bus_reset_in | (host_output_control_instruction_in & host_wdata_in[18]);
   sequence s_exdep_ask;
      port_examine_deposit_strobe_in && !clr;
   endsequence
   sequence s_intr_ask;
      (port_interrupt_request_strobe_in || internal_bus_contention_error_in) && !clr;
   endsequence
   present_view_a: assert property ($past(rst_b_in) |->
      host_rdata_out[0] && !port_rdata_out[0]) else $error("presence bit wrong");
   rsvd_bit_a: assert property (!host_rdata_out[3] && !port_rdata_out[3])
      else $error("bit three not zero");
   exdep_set_a: assert property (s_exdep_ask |=> exdep_intr_out)
      else $error("exam request not raised");
   exdep_hold_a: assert property (exdep_intr_out && !exdep_seq_done_in && !clr |=>
      exdep_intr_out) else $error("exam request dropped early");
   exdep_level_a: assert property (exdep_intr_level_out == 3'h0)
      else $error("exam level not zero");
   intr_set_a: assert property (s_intr_ask |-> ##[1:2] intr_out)
      else $error("interrupt request not raised");
   intr_hold_a: assert property (intr_out && !intr_seq_done_in && !clr |=> intr_out)
      else $error("interrupt request dropped early");
   clear_all_a: assert property (clr |=> !exdep_intr_out && !intr_out && !microprocessor_run_bit_out)
      else $error("clear left a request set");
   trap_halt_a: assert property (nonvec_trap_out |-> !microprocessor_run_bit_out &&
      nonvec_addr_out == 8'h20 + {4'h0, $past(intr_level_out), 1'b0}) else $error("trap wrong");
endmodule // hpc_csr_monitor

bind hpc_csr_status hpc_csr_monitor mon_u (.clk_in, .rst_b_in,
   .host_output_control_instruction_in, .host_wdata_in, .bus_reset_in, .exdep_seq_done_in,
   .intr_seq_done_in, .port_examine_deposit_strobe_in, .port_interrupt_request_strobe_in,
   .internal_bus_contention_error_in, .host_rdata_out, .port_rdata_out, .exdep_intr_out,
   .exdep_intr_level_out, .intr_out, .intr_level_out, .microprocessor_run_bit_out, .nonvec_trap_out,
   .nonvec_addr_out);

// [testbench/hpc_host_model.sv]
// Purpose: host side answering the two bus interrupt sequences
// Assumes: drives on the falling edge like the bench
// Notes:   slow_in stretches the answer to test holding
`timescale 1ns/1ps

module hpc_host_model (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic en_in,
   input  wire logic slow_in,
   input  wire logic exdep_intr_in,
   input  wire logic intr_in,
   output logic      exdep_done_out,
   output logic      intr_done_out
);
   logic [3:0] cnt_ff;
   // ==========================================
   // complete a sequence
   always @(negedge clk_in) begin
      exdep_done_out <= 1'b0;
      intr_done_out  <= 1'b0;
      cnt_ff         <= 4'h0;
      // level zero served first
      if (rst_b_in && en_in && (exdep_intr_in || intr_in) &&
          !exdep_done_out && !intr_done_out) begin
         cnt_ff <= cnt_ff + 4'h1;
         if (cnt_ff == (slow_in ? 4'h6 : 4'h1)) begin
            cnt_ff         <= 4'h0;
            exdep_done_out <= exdep_intr_in;
            intr_done_out  <= !exdep_intr_in;
         end
      end
   end
endmodule // hpc_host_model

// [testbench/hpc_csr_status_tb.sv]
// Purpose: self-checking bench for the status register block
// Assumes: inputs change on the falling edge
// Notes:   host model answers interrupt sequences when enabled
`timescale 1ns/1ps

module hpc_csr_status_tb;
   logic        clk_in = 0, rst_b_in = 0, wr_en = 0, par = 1, frc = 0, en = 0, slow = 0;
   logic [35:0] wd = 0;
   logic [8:0]  ev = 0;
   logic [47:0] csw = 0;
   wire  [35:0] hrd, prd;
   wire  [2:0]  xl, il;
   wire  [7:0]  taddr;
   wire         xi, ii, run, trap, xdone, idone;
   int          num_errors = 0, n_tests = 0, cycles = 0;
   bit          hit;
   localparam logic [35:0] RUNW = {3'h3, 1'b1, 32'h0};

   hpc_csr_status dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .host_output_control_instruction_in(wr_en), .host_wdata_in(wd), .bus_reset_in(ev[7]),
      .bus_parity_detect_in(ev[6]), .exdep_seq_done_in(xdone), .intr_seq_done_in(idone),
      .host_rdata_out(hrd), .exdep_intr_out(xi), .exdep_intr_level_out(xl), .intr_out(ii),
      .intr_level_out(il), .port_access_request_strobe_in(ev[0]),
      .port_register_read_strobe_in(ev[1]), .port_register_load_strobe_in(ev[2]),
      .port_examine_deposit_strobe_in(ev[3]), .port_interrupt_request_strobe_in(ev[4]),
      .internal_bus_contention_error_in(ev[5]), .cs_word_valid_in(ev[8]), .cs_word_in(csw),
      .cs_parity_in(par), .cs_force_err_in(frc), .port_rdata_out(prd), .microprocessor_run_bit_out(run),
      .nonvec_trap_out(trap), .nonvec_addr_out(taddr));
   hpc_host_model host_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .en_in(en), .slow_in(slow),
      .exdep_intr_in(xi), .intr_in(ii), .exdep_done_out(xdone), .intr_done_out(idone));

   // ==========================================
   // clock, watchdog and shared tasks
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic pulse(input int b);
      @(negedge clk_in) ev[b] = 1'b1;
      @(negedge clk_in) ev[b] = 1'b0;
   endtask
   task automatic wr(input logic [35:0] d);
      @(negedge clk_in);
      wd = d;
      wr_en = 1'b1;
      @(negedge clk_in) wr_en = 1'b0;
   endtask
   task automatic settle;
      repeat (2) @(negedge clk_in);
   endtask
   // polls a few cycles, the trap stands for one only
   task automatic wait_trap;
      hit = 0;
      repeat (6) @(negedge clk_in) if (trap === 1'b1) hit = 1;
   endtask
   task automatic wait_low;
      for (int i = 0; i < 20 && (xi !== 1'b0 || ii !== 1'b0); i++) @(negedge clk_in);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // scenarios
   task automatic t_present;
      wr(36'h8);
      settle();
      check(hrd[0], 1);
      check(prd[0], 0);
      check(hrd[3], 0);
      check(prd[3], 0);
      $display("presence test done");
   endtask
   task automatic t_diag;
      pulse(0);
      settle();
      check(hrd[1], 1);
      pulse(1);
      settle();
      check(hrd[1], 0);
      pulse(0);
      pulse(2);
      settle();
      check(hrd[1], 0);
      $display("diag test done");
   endtask
   task automatic t_changed;
      wr(36'h0);
      settle();
      check(hrd[2], 1);
      pulse(1);
      settle();
      check(hrd[2], 0);
      pulse(6);
      settle();
      check({hrd[24], hrd[2]}, 3);
      $display("changed test done");
   endtask
   task automatic t_intr;
      en = 1;
      slow = 1;
      pulse(3);
      check(xi, 1);
      check(xl, 0);
      settle();
      check(hrd[4], 1);
      wait_low();
      check(xi, 0);
      wr({3'h3, 33'h0});
      settle();
      check(il, 3);
      slow = 0;
      pulse(4);
      check(ii, 1);
      wait_low();
      check(ii, 0);
      en = 0;
      pulse(5);
      settle();
      check({hrd[7], ii}, 3);
      wr(36'h000040000);
      settle();
      $display("interrupt test done");
   endtask
   task automatic t_clear;
      pulse(3);
      pulse(4);
      pulse(0);
      wr(36'h000040000);
      settle();
      check(hrd[5:1], 0);
      check({xi, ii}, 0);
      pulse(3);
      pulse(4);
      pulse(7);
      settle();
      check(hrd[5:1], 0);
      $display("clear test done");
   endtask
   task automatic t_parity;
      wr(RUNW);
      settle();
      check(run, 1);
      par = 1;
      pulse(8);
      wait_trap();
      check(hit, 0);
      // odd word with parity low is still good: the word takes part
      csw = 48'h1;
      par = 0;
      pulse(8);
      wait_trap();
      check(hit, 0);
      csw = 48'h0;
      pulse(8);
      wait_trap();
      check(hit, 1);
      check(taddr, 8'h26);
      check(run, 0);
      settle();
      check({hrd[6], ii}, 3);
      wr(RUNW);
      settle();
      check(run, 0);
      wr(36'h001000000);
      settle();
      check(hrd[6], 0);
      check(il, 1);
      wr(RUNW);
      settle();
      check(run, 1);
      par = 1;
      frc = 1;
      pulse(8);
      frc = 0;
      wait_trap();
      check(hit, 1);
      check(run, 0);
      $display("parity test done");
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      @(negedge clk_in) rst_b_in = 1'b1;
      t_present(); t_diag(); t_changed(); t_intr(); t_clear(); t_parity();
      conclude();
   end
endmodule // hpc_csr_status_tb
